// >>> rtl/programmable_crc_engine.sv
// programmable crc engine with input fifo behind an avalon-mm slave
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "crc_defines.svh"
// How it works
// - width field bits 12:8 hold width-1
// - length field bits 4:0 hold length-1
// - low polynomial bits 15:1, bit0 reads zero
// - high polynomial bits enable terms 31..16
// - input writes push fifo, reads give zero
// - result writes load shift register halves while enabled
// - hardware updates result while shifting, readable live
// - count rises on msb byte write only
// - fifo depth 4, 8 or 16 by width
// - started engine pops words, shifts two bits
// - disabled module keeps fifo empty, count zero
module programmable_crc_engine (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [4:0]  avm_address,
  input  wire logic        avm_read,
  input  wire logic        avm_write,
  input  wire logic [31:0] avm_writedata,
  input  wire logic [3:0]  avm_byteenable,
  output logic [31:0]      avm_readdata,
  output logic             avm_waitrequest
);
  import crc_pkg::*;

  logic        enable;
  logic        go;
  crc_cfg_t    cfg;
  logic [15:1] poly_lo;
  logic [15:0] poly_hi;
  logic [31:0] sr;
  logic [31:0] stage;
  logic [31:0] buffer;
  logic [5:0]  bits_left;
  eng_state_t  state;
  fifo_stat_t  fstat;
  logic [31:0] head;

  function automatic logic at(input logic [4:0] a, input logic [4:0] ofs);
    return a[4:2] == ofs[4:2];
  endfunction

  function automatic logic [31:0] len_mask(input logic [4:0] poly_length_field);
    return 32'hffffffff >> (5'h1f - poly_length_field);
  endfunction

  // one serial step; the constant term is always fed back
  function automatic logic [31:0] crc_step(
    input logic [31:0] r,
    input logic        b,
    input logic [31:0] poly,
    input logic [4:0]  poly_length_field
  );
    logic        fb;
    logic [31:0] nr;
    fb = b ^ r[poly_length_field];
    nr = {r[30:0], 1'b0} ^ (fb ? poly : 32'h00000000);
    return nr & len_mask(poly_length_field);
  endfunction

  // bus decode: a write takes effect on the edge that sees waitrequest low
  wire req    = avm_read || avm_write;
  wire wr_go  = avm_write && !avm_waitrequest;
  wire rd_go  = avm_read && avm_waitrequest;
  wire w_ctl  = wr_go && at(avm_address, `CRC_ADDR_CONTROL);
  wire w_cfg  = wr_go && at(avm_address, `CRC_ADDR_CFG);
  wire w_plo  = wr_go && at(avm_address, `CRC_ADDR_POLY_LO);
  wire w_phi  = wr_go && at(avm_address, `CRC_ADDR_POLY_HI);
  wire w_inl  = wr_go && at(avm_address, `CRC_ADDR_IN_LO);
  wire w_inh  = wr_go && at(avm_address, `CRC_ADDR_IN_HI);
  wire w_rlo  = wr_go && at(avm_address, `CRC_ADDR_RES_LO);
  wire w_rhi  = wr_go && at(avm_address, `CRC_ADDR_RES_HI);
  wire [1:0] be = avm_byteenable[1:0];

  // per byte lane write enables and merged words
  wire [3:0]  in_we;
  wire [3:0]  res_we;
  wire [31:0] next_stage;
  wire [31:0] sw_sr;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_lane
      wire [7:0] wbyte = avm_writedata[8*(k%2) +: 8];
      wire       hi    = (k >= 2);
      assign in_we[k]  = (hi ? w_inh : w_inl) && be[k%2];
      assign res_we[k] = (hi ? w_rhi : w_rlo) && be[k%2];
      assign next_stage[8*k +: 8] = in_we[k] ? wbyte : stage[8*k +: 8];
      assign sw_sr[8*k +: 8] = res_we[k] ? wbyte : sr[8*k +: 8];
    end
  endgenerate

  wire [1:0] msb_lane = cfg.data_width_field[4:3];
  wire       push     = enable && in_we[msb_lane];

  // readback selection
  wire [15:0] ctl_word = {enable, 2'h0, fstat.count, fstat.full,
                          fstat.empty, 1'b0, go, cfg.lendian, 3'h0};
  wire [15:0] cfg_word = {3'h0, cfg.data_width_field, 3'h0, cfg.poly_length_field};
  wire [15:0] rd_value =
    at(avm_address, `CRC_ADDR_CONTROL) ? ctl_word :
    at(avm_address, `CRC_ADDR_CFG)     ? cfg_word :
    at(avm_address, `CRC_ADDR_POLY_LO) ? {poly_lo, 1'b0} :
    at(avm_address, `CRC_ADDR_POLY_HI) ? poly_hi :
    at(avm_address, `CRC_ADDR_RES_LO)  ? sr[15:0] :
    at(avm_address, `CRC_ADDR_RES_HI)  ? sr[31:16] :
                                         16'h0000;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avm_waitrequest <= 1'b1;
      avm_readdata    <= 32'h00000000;
    end else begin
      avm_waitrequest <= !(req && avm_waitrequest);
      if (rd_go) begin
        avm_readdata <= {16'h0000, rd_value};
      end
    end
  end

  // engine control
  wire       in_shift  = state == st_shift;
  wire       two_bits  = bits_left > 6'h01;
  wire       word_done = in_shift && (bits_left <= 6'h02);
  wire       can_pop   = go && !fstat.empty;
  // pop when idle or word ends
  wire       pop       = enable && can_pop &&
                         (state == st_idle || word_done);
  wire [4:0] dw_lo     = cfg.data_width_field - 5'h01;
  wire       b1        = cfg.lendian ? buffer[0] : buffer[cfg.data_width_field];
  wire       b2        = cfg.lendian ? buffer[1] : buffer[dw_lo];
  wire [31:0] poly     = {poly_hi, poly_lo, 1'b1};
  wire [31:0] sr_one   = crc_step(sr, b1, poly, cfg.poly_length_field);
  wire [31:0] sr_two   = crc_step(sr_one, b2, poly, cfg.poly_length_field);
  wire [31:0] shift_sr = two_bits ? sr_two : sr_one;
  wire [31:0] next_buffer = cfg.lendian ? {2'h0, buffer[31:2]}
                                        : {buffer[29:0], 2'h0};

  // width and length fields
  // the shift order bit sits in the control word but lives in the config
  // struct, so the whole struct keeps a single writer process
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg.data_width_field  <= `CRC_CFG_RST;
      cfg.poly_length_field    <= `CRC_CFG_RST;
      cfg.lendian <= 1'b0;
    end else begin
      if (w_cfg && be[1]) begin
        cfg.data_width_field <= avm_writedata[`CRC_DW_LSB +: 5];
      end
      if (w_cfg && be[0]) begin
        cfg.poly_length_field <= avm_writedata[`CRC_PL_LSB +: 5];
      end
      if (w_ctl && be[0]) begin
        cfg.lendian <= avm_writedata[`CRC_LE_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      poly_lo <= 15'(`CRC_POLY_RST >> 1);
      poly_hi <= `CRC_POLY_RST;
    end else begin
      if (w_plo && be[1]) begin
        poly_lo[15:8] <= avm_writedata[15:8];
      end
      if (w_plo && be[0]) begin
        poly_lo[7:1] <= avm_writedata[7:1];
      end
      if (w_phi && be[1]) begin
        poly_hi[15:8] <= avm_writedata[15:8];
      end
      if (w_phi && be[0]) begin
        poly_hi[7:0] <= avm_writedata[7:0];
      end
    end
  end

  // a software start wins over the hardware clear at completion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enable <= 1'b0;
      go     <= 1'b0;
    end else begin
      if (w_ctl && be[1]) begin
        enable <= avm_writedata[`CRC_EN_BIT];
      end
      if (w_ctl && be[0]) begin
        go <= avm_writedata[`CRC_GO_BIT];
      end else if (word_done && fstat.empty) begin
        go <= 1'b0;
      end
    end
  end

  // staging word; disabling drops a half written word
  always_ff @(posedge ref_clk) begin
    if (srst || !enable) begin
      stage <= 32'h00000000;
    end else begin
      stage <= next_stage;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !enable) begin
      state     <= st_idle;
      bits_left <= 6'h00;
      buffer    <= 32'h00000000;
    end else if (pop) begin
      state     <= st_shift;
      buffer    <= head;
      bits_left <= {1'b0, cfg.data_width_field} + 6'h01;
    end else if (word_done) begin
      state     <= st_idle;
      bits_left <= 6'h00;
    end else begin
      case (state)
        st_shift: begin
          bits_left <= bits_left - 6'h02;
          buffer    <= next_buffer;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // hardware update of result
  // software loads win over a shift in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst || !enable) begin
      sr <= `CRC_RES_RST;
    end else if (|res_we) begin
      sr <= sw_sr;
    end else if (in_shift) begin
      sr <= shift_sr;
    end
  end

  crc_fifo u_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .flush     (!enable),
    .data_width_field    (cfg.data_width_field),
    .push      (push),
    .push_data (next_stage),
    .pop       (pop),
    .head      (head),
    .stat      (fstat)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_width_store: assert property (
    w_cfg && be[1] |=> cfg.data_width_field == $past(avm_writedata[12:8]))
    else $error("width field not stored");

  a_poly_length_field_store: assert property (
    w_cfg && be[0] |=> cfg.poly_length_field == $past(avm_writedata[4:0]))
    else $error("length field not stored");

  a_poly_bit0: assert property (
    rd_go && at(avm_address, `CRC_ADDR_POLY_LO)
    |=> avm_readdata[0] == 1'b0 &&
        avm_readdata[15:1] == $past(poly_lo))
    else $error("low polynomial readback wrong");

  a_poly_high: assert property (
    w_phi && be == 2'h3 |=> poly_hi == $past(avm_writedata[15:0]))
    else $error("high polynomial not stored");

  a_input_zero: assert property (
    rd_go && (at(avm_address, `CRC_ADDR_IN_LO) ||
              at(avm_address, `CRC_ADDR_IN_HI))
    |=> avm_readdata == 32'h00000000)
    else $error("input register read not zero");

  a_result_load: assert property (
    enable && w_rhi && be == 2'h3
    |=> sr[31:16] == $past(avm_writedata[15:0]))
    else $error("result high not loaded");

  a_result_live: assert property (
    rd_go && at(avm_address, `CRC_ADDR_RES_LO)
    |=> avm_readdata[15:0] == $past(sr[15:0]))
    else $error("result read not live");

  a_msb_push: assert property (
    enable && w_inl && be == 2'h3 && cfg.data_width_field >= `CRC_DW_WIDE_MIN
    && !pop |=> fstat.count == $past(fstat.count))
    else $error("low half of wide word counted");

  a_two_bits: assert property (
    enable && in_shift && bits_left > 6'h02 && !pop
    |=> in_shift && bits_left == $past(bits_left) - 6'h02)
    else $error("shift rate not two bits");

  a_disabled_empty: assert property (
    !enable ##1 !enable |-> fstat.empty && fstat.count == 5'h00)
    else $error("fifo holds words while disabled");

  a_length_mask: assert property (
    enable && in_shift && !(|res_we)
    |=> (sr & ~len_mask(cfg.poly_length_field)) == 32'h00000000)
    else $error("remainder exceeds polynomial length");

  a_go_done: assert property (
    word_done && fstat.empty && !(w_ctl && be[0]) |=> !go)
    else $error("start bit not cleared at end of run");

  a_pop_count: assert property (
    pop && !push |=> fstat.count == $past(fstat.count) - 5'h01)
    else $error("word count not lowered by pop");

  a_push_count: assert property (
    push && !fstat.full && !pop
    |=> fstat.count == $past(fstat.count) + 5'h01)
    else $error("word count not raised by msb write");

  a_disabled_idle: assert property (
    !enable |=> state == st_idle && sr == 32'h00000000)
    else $error("engine active while disabled");

  c_lsb_first: cover property (in_shift && cfg.lendian);
  c_last_word: cover property (pop && fstat.count == 5'h01);
  c_run_done: cover property (word_done && fstat.empty ##1 !go);
  c_back_to_back: cover property (word_done && pop);
endmodule

// >>> rtl/crc_defines.svh
// register map, field positions, reset values and depths of the crc engine
`ifndef CRC_DEFINES_SVH
`define CRC_DEFINES_SVH
`define CRC_ADDR_CONTROL   5'h00
`define CRC_ADDR_CFG       5'h04
`define CRC_ADDR_POLY_LO   5'h08
`define CRC_ADDR_POLY_HI   5'h0c
`define CRC_ADDR_IN_LO     5'h10
`define CRC_ADDR_IN_HI     5'h14
`define CRC_ADDR_RES_LO    5'h18
`define CRC_ADDR_RES_HI    5'h1c
`define CRC_EN_BIT         15
`define CRC_GO_BIT         4
`define CRC_LE_BIT         3
`define CRC_DW_LSB         8
`define CRC_PL_LSB         0
`define CRC_CFG_RST        5'h00
`define CRC_POLY_RST       16'h0000
`define CRC_RES_RST        32'h00000000
`define CRC_DW_WIDE_MIN    5'h10
`define CRC_DW_MID_MIN     5'h08
`define CRC_DEPTH_WIDE     5'h04
`define CRC_DEPTH_MID      5'h08
`define CRC_DEPTH_NARROW   5'h10
`endif

// >>> rtl/crc_pkg.sv
// types shared by the crc engine and its input fifo
package crc_pkg;
  typedef struct packed {
    logic [4:0] data_width_field;
    logic [4:0] poly_length_field;
    logic       lendian;
  } crc_cfg_t;
  typedef struct packed {
    logic [4:0] count;
    logic       full;
    logic       empty;
  } fifo_stat_t;
  typedef enum logic [1:0] {
    st_idle  = 2'b01,
    st_shift = 2'b10
  } eng_state_t;
endpackage

// >>> rtl/crc_fifo.sv
// input word fifo whose usable depth follows the data width
`timescale 1ns/1ps
`include "crc_defines.svh"
module crc_fifo (
  input  wire logic          ref_clk,
  input  wire logic          srst,
  input  wire logic          flush,
  input  wire logic [4:0]    data_width_field,
  input  wire logic          push,
  input  wire logic [31:0]   push_data,
  input  wire logic          pop,
  output logic [31:0]        head,
  output crc_pkg::fifo_stat_t stat
);
  import crc_pkg::*;

  logic [31:0] mem [16];
  logic [3:0]  wr_ptr;
  logic [3:0]  rd_ptr;
  logic [4:0]  count;

  wire [4:0] limit = (data_width_field >= `CRC_DW_WIDE_MIN) ? `CRC_DEPTH_WIDE :
                     (data_width_field >= `CRC_DW_MID_MIN)  ? `CRC_DEPTH_MID :
                                                    `CRC_DEPTH_NARROW;
  // a push into a full fifo is dropped, software watches the full flag
  wire       do_push = push && (count < limit);
  wire       do_pop  = pop && (count != 5'h00);
  wire [4:0] next_count = count + {4'h0, do_push} - {4'h0, do_pop};

  assign head       = mem[rd_ptr];
  assign stat.count = count;
  assign stat.full  = count >= limit;
  assign stat.empty = count == 5'h00;

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 5'h00;
    end else begin
      wr_ptr <= wr_ptr + {3'h0, do_push};
      rd_ptr <= rd_ptr + {3'h0, do_pop};
      count  <= next_count;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_full_refuses: assert property (
    push && stat.full && !pop && !flush |=> count == $past(count))
    else $error("push accepted into a full fifo");
  a_disable_flush: assert property (
    flush |=> count == 5'h00 && stat.empty)
    else $error("fifo not emptied while disabled");
  c_fifo_full: cover property (stat.full && data_width_field >= `CRC_DW_WIDE_MIN);
endmodule

// >>> dv/test_programmable_crc_engine.sv
// self-checking testbench of the programmable crc engine register interface
`timescale 1ns/1ps
`include "crc_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_programmable_crc_engine;
  logic        ref_clk;
  logic        srst;
  logic [4:0]  avm_address;
  logic        avm_read;
  logic        avm_write;
  logic [31:0] avm_writedata;
  logic [3:0]  avm_byteenable;
  logic [31:0] avm_readdata;
  logic        avm_waitrequest;
  logic [15:0] q;
  int          n_errors;
  int          checks_done;
  int          cycles;

  programmable_crc_engine i_dut (
    .ref_clk         (ref_clk),
    .srst            (srst),
    .avm_address     (avm_address),
    .avm_read        (avm_read),
    .avm_write       (avm_write),
    .avm_writedata   (avm_writedata),
    .avm_byteenable  (avm_byteenable),
    .avm_readdata    (avm_readdata),
    .avm_waitrequest (avm_waitrequest)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hung handshake or a go bit that never clears ends up here
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // one avalon transfer; the extra edge after release keeps back to back
  // calls from assigning read or write twice in one time step
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    avm_address    <= a;
    avm_write      <= w;
    avm_read       <= !w;
    avm_writedata  <= {16'h0000, d};
    avm_byteenable <= 4'hf;
    do @(posedge ref_clk); while (avm_waitrequest !== 1'b0);
    q = avm_readdata[15:0];
    avm_write <= 1'b0;
    avm_read  <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [31:0] len_mask(int pl);
    return (pl == 31) ? 32'hffffffff : ((32'h1 << (pl + 1)) - 32'h1);
  endfunction

  // bit-serial reference: input xor top bit feeds every enabled term
  function automatic logic [31:0] crc_word(logic [31:0] sr, logic [31:0] w,
      int dw, int pl, logic [31:0] poly, logic lsb);
    logic b;
    logic fb;
    for (int i = 0; i <= dw; i++) begin
      b  = lsb ? w[i] : w[dw - i];
      fb = b ^ sr[pl];
      sr = ((sr << 1) ^ (fb ? poly : 32'h0)) & len_mask(pl);
    end
    return sr;
  endfunction

  int          dws[3] = '{31, 15, 7};
  int          deps[3] = '{4, 8, 16};
  int          dw;
  int          pl;
  int          dep;
  logic        lsb;
  logic [15:0] plo;
  logic [15:0] phi;
  logic [31:0] w;
  logic [31:0] sr;
  logic [15:0] ctl;

  initial begin
    srst = 1'b1;
    avm_address = 5'h00;
    avm_read = 1'b0;
    avm_write = 1'b0;
    avm_writedata = 32'h00000000;
    avm_byteenable = 4'h0;
    void'($urandom(32'h54370716));
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, 5'(a * 4), 16'h0000);
      `CHK(q, (a == 0) ? 16'h0040 : 16'h0000)
    end
    bus(1'b1, `CRC_ADDR_CFG, 16'hffff);
    bus(1'b0, `CRC_ADDR_CFG, 16'h0000);
    `CHK(q, 16'h1f1f)
    bus(1'b1, `CRC_ADDR_POLY_LO, 16'hffff);
    bus(1'b0, `CRC_ADDR_POLY_LO, 16'h0000);
    `CHK(q, 16'hfffe)
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, `CRC_ADDR_IN_LO + 5'(a * 4), 16'(16'($urandom()) | 16'h1));
      bus(1'b0, `CRC_ADDR_IN_LO + 5'(a * 4), 16'h0000);
      `CHK(q, 16'h0000)
    end
    for (int c = 0; c < 3; c++) begin
      dw  = dws[c];
      dep = deps[c];
      // both shift orders are reached; the length differs from the width except in the first pass
      pl  = 31 - 8 * c;
      lsb = 1'(c);
      plo = 16'($urandom());
      phi = 16'($urandom());
      ctl = 16'h8000 | {12'h000, lsb, 3'b000};
      bus(1'b1, `CRC_ADDR_POLY_LO, plo);
      bus(1'b1, `CRC_ADDR_POLY_HI, phi);
      bus(1'b0, `CRC_ADDR_POLY_HI, 16'h0000);
      `CHK(q, phi)
      bus(1'b1, `CRC_ADDR_CFG, {3'b000, 5'(dw), 3'b000, 5'(pl)});
      bus(1'b1, `CRC_ADDR_CONTROL, ctl);
      sr = 32'($urandom()) & len_mask(pl);
      bus(1'b1, `CRC_ADDR_RES_LO, sr[15:0]);
      bus(1'b1, `CRC_ADDR_RES_HI, sr[31:16]);
      bus(1'b0, `CRC_ADDR_RES_LO, 16'h0000);
      `CHK(q, sr[15:0])
      bus(1'b0, `CRC_ADDR_RES_HI, 16'h0000);
      `CHK(q, sr[31:16])
      // one push beyond the depth must be dropped
      for (int k = 0; k <= dep; k++) begin
        w = 32'($urandom());
        bus(1'b1, `CRC_ADDR_IN_LO, w[15:0]);
        if (dw >= 16) begin
          bus(1'b0, `CRC_ADDR_CONTROL, 16'h0000);
          `CHK(q[12:8], 5'((k < dep) ? k : dep))
          bus(1'b1, `CRC_ADDR_IN_HI, w[31:16]);
        end
        bus(1'b0, `CRC_ADDR_CONTROL, 16'h0000);
        `CHK(q[12:8], 5'((k < dep) ? k + 1 : dep))
        if (k < dep) begin
          sr = crc_word(sr, w, dw, pl, {phi, plo[15:1], 1'b1}, lsb);
        end
      end
      `CHK(q, ctl | 16'(dep << 8) | 16'h0080)
      bus(1'b1, `CRC_ADDR_CONTROL, ctl | 16'h0010);
      do bus(1'b0, `CRC_ADDR_CONTROL, 16'h0000); while (q[4] !== 1'b0);
      `CHK(q, ctl | 16'h0040)
      bus(1'b0, `CRC_ADDR_RES_LO, 16'h0000);
      `CHK(q, sr[15:0])
      bus(1'b0, `CRC_ADDR_RES_HI, 16'h0000);
      `CHK(q, sr[31:16])
    end
    bus(1'b1, `CRC_ADDR_IN_LO, 16'h00a5);
    bus(1'b1, `CRC_ADDR_IN_LO, 16'h005a);
    bus(1'b1, `CRC_ADDR_CONTROL, 16'h0000);
    bus(1'b0, `CRC_ADDR_CONTROL, 16'h0000);
    `CHK(q, 16'h0040)
    // a reset of the disabled engine brings config and terms back to zero
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, `CRC_ADDR_CFG, 16'h0000);
    `CHK(q, 16'h0000)
    bus(1'b0, `CRC_ADDR_POLY_HI, 16'h0000);
    `CHK(q, 16'h0000)
    report_and_stop();
  end
endmodule
